// ---- logic/aic_control.sv ----
// input pairing, mode, sequence, calibration, timing and address control
// Function
// - pairing 00/11 is two single-ended; reset default
// - two-channel mode: cap2 on ground, cap1 selected
// - reset: manual, channel 0 only; modes 000/001
// - channel in sequence only when its bit set
// - modes 100/101 manual seq, 110 autonomous, 111 precision
// - pairing 01: cap1 pin zero, cap2 pin one
// - pairing 10: pseudo-differential, pin zero/pin one
// - single-channel with channel 1 enabled flags error
// - calibration: switches open, busy high, offset corrected
// - calibration runs by itself after reset
// - results are 12-bit unsigned straight binary
// - codes 000, 800, fff at scale points
// - oscillator choice 1 low-power, 0 high-speed
// - conversion cycle lasts cycle-length oscillator clocks
// - strap address latched after reset release, kept until rewritten
// - strap decodes to 18h..1fh
// - pairing taken from input config register
// - manual: host starts; autonomous: device starts
module aic_control
  import aic_pkg::*;
#(
  parameter int HSO_DIV = 1,
  parameter int LPO_DIV = 64
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] addrStrap,
  input wire aic_raw_t rawResult,
  output aic_mux_t muxCtl,
  output logic convStart,
  output logic busyRdy,
  output logic [6:0] slaveAddr,
  output logic irq
);

  // configuration registers
  logic [1:0] inputPairingCfg_reg;
  logic [2:0] operatingModeSelect_reg;
  logic [1:0] sequenceChannelEnable_reg;
  logic oscillatorChoice_reg;
  logic [7:0] conversionCycleLength_reg;
  logic [AIC_IRQ_W-1:0] irqStatus_reg;
  logic [AIC_IRQ_W-1:0] irqMask_reg;
  logic [AIC_IRQ_W-1:0] irqEvents;
  // datapath state
  aic_state_t state_reg;
  logic calPending_reg;
  logic startPending_reg;
  logic signed [12:0] offset_reg;
  logic [11:0] result_reg;
  logic resultChan_reg;
  logic chan_reg;
  logic [7:0] tickCnt_reg;
  logic seqErrPrev_reg;
  // divider state
  logic [7:0] hsoCnt_reg;
  logic [7:0] lpoCnt_reg;
  logic hsoTick_reg;
  logic lpoTick_reg;
  // strap capture
  logic [2:0] strapS1_reg;
  logic [2:0] strapS2_reg;
  logic [2:0] strapS3_reg;
  logic [1:0] settle_reg;
  logic strapTaken_reg;
  // bus decode
  logic busReq;
  logic busWr;
  logic [31:0] readData;
  // derived
  logic singleChannel;
  logic autoSeq;
  logic autonomous;
  logic seqError;
  logic oscTick;
  logic firstChan;
  logic signed [13:0] corrected;
  logic [11:0] correctedCode;

  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWr = busReq && wb_we_i && wb_sel_i[0];

  // mode decode
  assign singleChannel = (inputPairingCfg_reg == AIC_PAIR_ONE_SE_RGS) ||
                         (inputPairingCfg_reg == AIC_PAIR_PSEUDO_DIFF);
  assign autoSeq = operatingModeSelect_reg[AIC_MODE_SEQ_BIT];
  assign autonomous = (operatingModeSelect_reg == AIC_MODE_AUTONOMOUS) ||
                      (operatingModeSelect_reg == AIC_MODE_HIGH_PREC);
  assign seqError = singleChannel && sequenceChannelEnable_reg[1];
  assign oscTick = oscillatorChoice_reg ? lpoTick_reg : hsoTick_reg;
  // first channel of a run: channel 0 unless a sequence mode has only channel 1 enabled
  assign firstChan = autoSeq && !sequenceChannelEnable_reg[0];

  // offset removal with clamp to the unsigned code range
  assign corrected = $signed({2'b00, rawResult.code}) - 14'(offset_reg);
  always_comb
  begin
    if (corrected < 0)
    begin
      correctedCode = AIC_CODE_NFS;
    end
    else if (corrected > $signed({2'b00, AIC_CODE_PFS}))
    begin
      correctedCode = AIC_CODE_PFS;
    end
    else
    begin
      correctedCode = corrected[AIC_RES_BITS-1:0];
    end
  end

  // oscillator stand-ins: enable pulses divided from clk
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      hsoCnt_reg <= 8'h00;
      lpoCnt_reg <= 8'h00;
      hsoTick_reg <= 1'b0;
      lpoTick_reg <= 1'b0;
    end
    else
    begin
      hsoTick_reg <= (hsoCnt_reg == 8'(HSO_DIV - 1));
      hsoCnt_reg <= (hsoCnt_reg == 8'(HSO_DIV - 1)) ? 8'h00 : hsoCnt_reg + 8'h01;
      lpoTick_reg <= (lpoCnt_reg == 8'(LPO_DIV - 1));
      lpoCnt_reg <= (lpoCnt_reg == 8'(LPO_DIV - 1)) ? 8'h00 : lpoCnt_reg + 8'h01;
    end
  end

  // strap synchroniser, three stages
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      strapS1_reg <= 3'h0;
      strapS2_reg <= 3'h0;
      strapS3_reg <= 3'h0;
    end
    else
    begin
      strapS1_reg <= addrStrap;
      strapS2_reg <= strapS1_reg;
      strapS3_reg <= strapS2_reg;
    end
  end

  // address taken once after reset release, then held or rewritten by software
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      settle_reg <= 2'h0;
      strapTaken_reg <= 1'b0;
      slaveAddr <= AIC_ADDR_BASE;
    end
    else if (!strapTaken_reg)
    begin
      if (settle_reg != AIC_STRAP_SETTLE)
      begin
        settle_reg <= settle_reg + 2'h1;
      end
      else if (strapS2_reg == strapS3_reg)
      begin
        slaveAddr <= AIC_ADDR_BASE + {4'h0, strapS3_reg};
        strapTaken_reg <= 1'b1;
      end
    end
    else if (busWr && wb_adr_i == AIC_OFS_SLAVE_ADDR)
    begin
      slaveAddr <= wb_dat_i[6:0];
    end
  end

  // configuration writes
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      inputPairingCfg_reg <= AIC_RST_PAIRING;
      operatingModeSelect_reg <= AIC_RST_OPMODE;
      sequenceChannelEnable_reg <= AIC_RST_CHEN;
      oscillatorChoice_reg <= AIC_RST_OSC;
      conversionCycleLength_reg <= AIC_RST_NCLK;
      irqMask_reg <= '0;
    end
    else if (busWr)
    begin
      case (wb_adr_i)
        AIC_OFS_INPUT_CFG: inputPairingCfg_reg <= wb_dat_i[1:0];
        AIC_OFS_OPMODE: operatingModeSelect_reg <= wb_dat_i[2:0];
        AIC_OFS_SEQ_CHEN: sequenceChannelEnable_reg <= wb_dat_i[1:0];
        AIC_OFS_OSC: oscillatorChoice_reg <= wb_dat_i[0];
        AIC_OFS_NCLK: conversionCycleLength_reg <= wb_dat_i[7:0];
        AIC_OFS_IRQ_MASK: irqMask_reg <= wb_dat_i[AIC_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // calibration request: set by trigger, cleared when taken
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      calPending_reg <= 1'b0; // power-up run entered from reset, no second pass
    end
    else if (busWr && wb_adr_i == AIC_OFS_OFFSET_CAL && wb_dat_i[0])
    begin
      calPending_reg <= 1'b1;
    end
    else if (state_reg == AIC_IDLE)
    begin
      calPending_reg <= 1'b0;
    end
  end

  // host start request, taken when idle with no calibration pending, in any mode
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      startPending_reg <= 1'b0;
    end
    else if (busWr && wb_adr_i == AIC_OFS_CONV_START && wb_dat_i[0])
    begin
      startPending_reg <= 1'b1;
    end
    else if (state_reg == AIC_IDLE && !calPending_reg)
    begin
      startPending_reg <= 1'b0;
    end
  end

  // conversion sequencer
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg <= AIC_CAL_ACQ;
      tickCnt_reg <= 8'h00;
      chan_reg <= 1'b0;
      convStart <= 1'b0;
      offset_reg <= '0;
      result_reg <= AIC_CODE_NFS;
      resultChan_reg <= 1'b0;
    end
    else
    begin
      convStart <= 1'b0;
      case (state_reg)
        AIC_IDLE:
        begin
          tickCnt_reg <= 8'h00;
          chan_reg <= firstChan;
          if (calPending_reg)
          begin
            state_reg <= AIC_CAL_ACQ;
          end
          else if (!seqError && !(autoSeq && sequenceChannelEnable_reg == 2'h0) &&
                   (autonomous || startPending_reg))
          begin
            state_reg <= AIC_ACQ;
          end
        end
        AIC_CAL_ACQ:
        begin
          if (oscTick)
          begin
            convStart <= 1'b1;
            state_reg <= AIC_CAL_CONV;
          end
        end
        AIC_CAL_CONV:
        begin
          if (rawResult.valid)
          begin
            offset_reg <= $signed({1'b0, rawResult.code}) - $signed({1'b0, AIC_CODE_MID});
            state_reg <= AIC_IDLE;
          end
        end
        AIC_ACQ:
        begin
          if (oscTick)
          begin
            if (tickCnt_reg + 8'h01 >= conversionCycleLength_reg)
            begin
              tickCnt_reg <= 8'h00;
              convStart <= 1'b1;
              state_reg <= AIC_CONV;
            end
            else
            begin
              tickCnt_reg <= tickCnt_reg + 8'h01;
            end
          end
        end
        AIC_CONV:
        begin
          if (rawResult.valid)
          begin
            result_reg <= correctedCode;
            resultChan_reg <= chan_reg;
            if (autoSeq && !chan_reg && sequenceChannelEnable_reg[1] && !seqError)
            begin
              chan_reg <= 1'b1;
              state_reg <= AIC_ACQ;
            end
            else
            begin
              state_reg <= AIC_IDLE;
            end
          end
        end
        default: state_reg <= AIC_IDLE;
      endcase
    end
  end

  // front-end steering and busy indication
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      muxCtl <= '0;
      busyRdy <= 1'b1;
    end
    else
    begin
      busyRdy <= (state_reg != AIC_IDLE);
      muxCtl.sampleClosed <= (state_reg == AIC_ACQ);
      muxCtl.calibrate <= (state_reg == AIC_CAL_ACQ) || (state_reg == AIC_CAL_CONV);
      if (singleChannel)
      begin
        muxCtl.cap1OnPinOne <= 1'b0;
        muxCtl.cap2OnPinOne <= 1'b1;
      end
      else
      begin
        muxCtl.cap1OnPinOne <= chan_reg;
        muxCtl.cap2OnPinOne <= 1'b0;
      end
    end
  end

  // interrupt events
  always_comb
  begin
    irqEvents = '0;
    irqEvents[AIC_IRQ_CONV] = (state_reg == AIC_CONV) && rawResult.valid;
    irqEvents[AIC_IRQ_CAL] = (state_reg == AIC_CAL_CONV) && rawResult.valid;
    irqEvents[AIC_IRQ_SEQERR] = seqError && !seqErrPrev_reg;
  end

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      irqStatus_reg <= '0;
      seqErrPrev_reg <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      seqErrPrev_reg <= seqError;
      if (busWr && wb_adr_i == AIC_OFS_IRQ_STATUS)
      begin
        irqStatus_reg <= (irqStatus_reg & ~wb_dat_i[AIC_IRQ_W-1:0]) | irqEvents;
      end
      else
      begin
        irqStatus_reg <= irqStatus_reg | irqEvents;
      end
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  // read mux, unmapped offsets read zero
  always_comb
  begin
    readData = 32'h0000_0000;
    case (wb_adr_i)
      AIC_OFS_INPUT_CFG: readData[1:0] = inputPairingCfg_reg;
      AIC_OFS_OPMODE: readData[2:0] = operatingModeSelect_reg;
      AIC_OFS_SEQ_CHEN: readData[1:0] = sequenceChannelEnable_reg;
      AIC_OFS_SEQ_STATUS: readData[2:0] = {calPending_reg, state_reg != AIC_IDLE, seqError};
      AIC_OFS_OFFSET_CAL: readData[0] = calPending_reg;
      AIC_OFS_OSC: readData[0] = oscillatorChoice_reg;
      AIC_OFS_NCLK: readData[7:0] = conversionCycleLength_reg;
      AIC_OFS_RESULT: readData[12:0] = {resultChan_reg, result_reg};
      AIC_OFS_OFFSET: readData[12:0] = offset_reg;
      AIC_OFS_SLAVE_ADDR: readData[6:0] = slaveAddr;
      AIC_OFS_IRQ_STATUS: readData[AIC_IRQ_W-1:0] = irqStatus_reg;
      AIC_OFS_IRQ_MASK: readData[AIC_IRQ_W-1:0] = irqMask_reg;
      default: readData = 32'h0000_0000;
    endcase
  end

  // wishbone classic slave, one wait state
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? readData : 32'h0000_0000;
    end
  end

endmodule

// ---- logic/aic_pkg.sv ----
// constants and carrier types for the converter input, mode and address control
package aic_pkg;
  // register byte offsets
  localparam logic [7:0] AIC_OFS_INPUT_CFG = 8'h00;
  localparam logic [7:0] AIC_OFS_OPMODE = 8'h04;
  localparam logic [7:0] AIC_OFS_SEQ_CHEN = 8'h08;
  localparam logic [7:0] AIC_OFS_SEQ_STATUS = 8'h0c;
  localparam logic [7:0] AIC_OFS_OFFSET_CAL = 8'h10;
  localparam logic [7:0] AIC_OFS_OSC = 8'h14;
  localparam logic [7:0] AIC_OFS_NCLK = 8'h18;
  localparam logic [7:0] AIC_OFS_CONV_START = 8'h1c;
  localparam logic [7:0] AIC_OFS_RESULT = 8'h20;
  localparam logic [7:0] AIC_OFS_OFFSET = 8'h24;
  localparam logic [7:0] AIC_OFS_SLAVE_ADDR = 8'h28;
  localparam logic [7:0] AIC_OFS_IRQ_STATUS = 8'h2c;
  localparam logic [7:0] AIC_OFS_IRQ_MASK = 8'h30;
  // input pairing encodings
  localparam logic [1:0] AIC_PAIR_TWO_SE_A = 2'h0;
  localparam logic [1:0] AIC_PAIR_ONE_SE_RGS = 2'h1;
  localparam logic [1:0] AIC_PAIR_PSEUDO_DIFF = 2'h2;
  localparam logic [1:0] AIC_PAIR_TWO_SE_B = 2'h3;
  // operating mode select: top bit means auto sequence, low bits refine it
  localparam logic [2:0] AIC_MODE_AUTONOMOUS = 3'h6;
  localparam logic [2:0] AIC_MODE_HIGH_PREC = 3'h7;
  localparam int AIC_MODE_SEQ_BIT = 2;
  // reset values
  localparam logic [1:0] AIC_RST_PAIRING = 2'h0;
  localparam logic [2:0] AIC_RST_OPMODE = 3'h0;
  localparam logic [1:0] AIC_RST_CHEN = 2'h1;
  localparam logic AIC_RST_OSC = 1'h0;
  localparam logic [7:0] AIC_RST_NCLK = 8'h15;
  // slave address base: strap value is added
  localparam logic [6:0] AIC_ADDR_BASE = 7'h18;
  // transfer function
  localparam int AIC_RES_BITS = 12;
  localparam logic [11:0] AIC_CODE_NFS = 12'h000;
  localparam logic [11:0] AIC_CODE_MID = 12'h800;
  localparam logic [11:0] AIC_CODE_PFS = 12'hfff;
  // interrupt bit positions
  localparam int AIC_IRQ_CONV = 0;
  localparam int AIC_IRQ_CAL = 1;
  localparam int AIC_IRQ_SEQERR = 2;
  localparam int AIC_IRQ_W = 3;
  // strap settle: cycles after reset before the strap is taken
  localparam logic [1:0] AIC_STRAP_SETTLE = 2'h3;

  // controller states
  typedef enum logic [2:0] {AIC_IDLE, AIC_CAL_ACQ, AIC_CAL_CONV, AIC_ACQ, AIC_CONV} aic_state_t;

  // sampling front-end steering
  typedef struct packed {
    logic sampleClosed; // both sampling switches closed
    logic cap1OnPinOne; // first cap: 0 pin zero, 1 pin one
    logic cap2OnPinOne; // second cap: 0 ground, 1 pin one
    logic calibrate;    // converter inputs shorted for offset measure
  } aic_mux_t;

  // converter core answer
  typedef struct packed {
    logic valid;
    logic [11:0] code;
  } aic_raw_t;
endpackage

// ---- tb/aic_control_assertions.sv ----
// concurrent checks on the control block ports
module aic_control_checker
  import aic_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [2:0] addrStrap,
  input wire aic_raw_t rawResult,
  input wire aic_mux_t muxCtl,
  input wire logic convStart,
  input wire logic busyRdy,
  input wire logic [6:0] slaveAddr,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic [1:0] pairReg;
  logic [3:0] relCnt;
  logic take;
  // a bus write taken on this edge
  assign take = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & wb_sel_i[0];
  // shadow of the pairing field and time since reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pairReg <= 2'h0;
      relCnt <= 4'h0;
    end
    else
    begin
      if (take && wb_adr_i == AIC_OFS_INPUT_CFG)
        pairReg <= wb_dat_i[1:0];
      if (relCnt != 4'hf)
        relCnt <= relCnt + 4'h1;
    end
  end
  property p_ack_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_start_pulse;
    convStart |-> busyRdy ##1 !convStart;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse bad");
  property p_cal_open;
    muxCtl.calibrate |-> !muxCtl.sampleClosed && busyRdy;
  endproperty
  a_cal_open: assert property (p_cal_open) else $error("switches closed in calibration");
  property p_two_se;
    muxCtl.sampleClosed && !muxCtl.calibrate && pairReg inside {2'h0, 2'h3}
      |-> !muxCtl.cap2OnPinOne;
  endproperty
  a_two_se: assert property (p_two_se) else $error("second cap not on ground");
  property p_one_ch;
    muxCtl.sampleClosed && !muxCtl.calibrate && pairReg inside {2'h1, 2'h2}
      |-> !muxCtl.cap1OnPinOne && muxCtl.cap2OnPinOne;
  endproperty
  a_one_ch: assert property (p_one_ch) else $error("single channel steering bad");
  property p_addr_range;
    slaveAddr[6:3] == 4'h3;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address out of range");
  property p_addr_kept;
    relCnt == 4'hf && !$past(take) && !$past(take, 2) |-> $stable(slaveAddr);
  endproperty
  a_addr_kept: assert property (p_addr_kept) else $error("address moved");
  property p_cal_on_reset;
    $rose(nrst) |-> busyRdy ##[1:300] convStart;
  endproperty
  a_cal_on_reset: assert property (p_cal_on_reset) else $error("no calibration");
endmodule

bind aic_control aic_control_checker chk_u (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .addrStrap(addrStrap),
  .rawResult(rawResult), .muxCtl(muxCtl), .convStart(convStart), .busyRdy(busyRdy),
  .slaveAddr(slaveAddr), .irq(irq));

// ---- tb/aic_core_model.sv ----
// converter core stand-in answering each start request
module aic_core_model
  import aic_pkg::*;
#(
  parameter int LAT = 4
)
(
  input wire logic clk,
  input wire logic convStart,
  input wire aic_mux_t muxCtl,
  input wire logic [11:0] convCode,
  input wire logic [11:0] calCode,
  output aic_raw_t rawResult
);
  int cnt = 0;
  initial rawResult = '0;
  // answer LAT cycles after a start, code churns when not valid
  always @(posedge clk)
  begin
    rawResult.valid <= (cnt == 1);
    rawResult.code <= (cnt == 1) ? (muxCtl.calibrate ? calCode : convCode) : ~rawResult.code;
    if (convStart)
      cnt <= LAT;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule

// ---- tb/aic_control_tb.sv ----
// self-checking bench for the control block
module aic_control_tb
  import aic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, cyc, stb, we, ack, convStart, busyRdy, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat;
  logic [2:0] strap;
  logic [6:0] slaveAddr;
  logic [11:0] convCode, calCode;
  aic_raw_t raw;
  aic_mux_t mux;
  int errors = 0, comparisons = 0, cycles = 0, nStart = 0;
  aic_control #(.HSO_DIV(1), .LPO_DIV(4)) dut_u (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .addrStrap(strap), .rawResult(raw), .muxCtl(mux),
    .convStart(convStart), .busyRdy(busyRdy), .slaveAddr(slaveAddr), .irq(irq));
  aic_core_model core_u (.clk(clk), .convStart(convStart), .muxCtl(mux), .convCode(convCode),
    .calCode(calCode), .rawResult(raw));
  // clock
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // start counter and hang guard
  always @(posedge clk)
  begin
    nStart <= nStart + int'(convStart);
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic wbw(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbx(1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wbx(0, a, 0, q);
    chk($sformatf("reg%h", a), e, q);
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_idle();
    cyc_n(3);
    while (busyRdy !== 1'b0) @(posedge clk);
  endtask
  task automatic do_reset();
    @(posedge clk);
    nrst <= 0;
    cyc_n(12);
    nrst <= 1;
    wait_idle();
  endtask
  // reset values, offset from power-up calibration, unmapped place
  task automatic t_defaults();
    rc(AIC_OFS_INPUT_CFG, 0);
    rc(AIC_OFS_OPMODE, 0);
    rc(AIC_OFS_SEQ_CHEN, 1);
    rc(AIC_OFS_NCLK, 32'h15);
    rc(AIC_OFS_OSC, 0);
    rc(AIC_OFS_OFFSET, 5);
    rc(8'h3c, 0);
    chk("addr", 7'h1e, slaveAddr);
  endtask
  // offset-corrected codes at the scale points
  task automatic t_manual();
    logic [11:0] cin [3] = '{12'h805, 12'h003, 12'hfff};
    logic [11:0] cex [3] = '{12'h800, 12'h000, 12'hffa};
    for (int i = 0; i < 3; i++)
    begin
      convCode <= cin[i];
      wbw(AIC_OFS_CONV_START, 1);
      wait_idle();
      rc(AIC_OFS_RESULT, {20'h0, cex[i]});
    end
    rc(AIC_OFS_IRQ_STATUS, 3);
    convCode <= 12'h805;
  endtask
  // host-triggered calibration: busy held, new offset applied to later codes
  task automatic t_cal();
    calCode <= 12'h7f0;
    wbw(AIC_OFS_OFFSET_CAL, 1);
    cyc_n(2);
    chk("busy", 1, busyRdy);
    wait_idle();
    rc(AIC_OFS_OFFSET, 32'h1ff0);
    wbw(AIC_OFS_CONV_START, 1);
    wait_idle();
    rc(AIC_OFS_RESULT, 32'h815);
    calCode <= 12'h805;
    wbw(AIC_OFS_OFFSET_CAL, 1);
    wait_idle();
    rc(AIC_OFS_OFFSET, 5);
  endtask
  // mode codes 000, 001 and 100 to 111: who starts and how many channels
  task automatic t_modes();
    logic [2:0] ml [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    int n0, k;
    wbw(AIC_OFS_INPUT_CFG, 3);
    wbw(AIC_OFS_SEQ_CHEN, 3);
    foreach (ml[i])
    begin
      wbw(AIC_OFS_OPMODE, ml[i]);
      n0 = nStart;
      if (ml[i] < 6)
      begin
        cyc_n(20);
        chk("self", n0, nStart);
        wbw(AIC_OFS_CONV_START, 1);
        wait_idle();
        chk("starts", n0 + ((ml[i] < 4) ? 1 : 2), nStart);
      end
      else
      begin
        k = 0;
        while (nStart - n0 < 3 && k < 3000)
        begin
          @(posedge clk);
          k++;
        end
        chk("auto", 1, nStart - n0 >= 3);
        wbw(AIC_OFS_OPMODE, 0);
        wait_idle();
      end
    end
    wbw(AIC_OFS_SEQ_CHEN, 2);
    wbw(AIC_OFS_OPMODE, 4);
    wbw(AIC_OFS_CONV_START, 1);
    wait_idle();
    rc(AIC_OFS_RESULT, 32'h1800);
    wbw(AIC_OFS_SEQ_CHEN, 0);
    n0 = nStart;
    wbw(AIC_OFS_CONV_START, 1);
    cyc_n(30);
    chk("none", n0, nStart);
    wbw(AIC_OFS_OPMODE, 0);
    wbw(AIC_OFS_SEQ_CHEN, 1);
  endtask
  // illegal sequence in single-channel pairings, interrupt raise, mask, clear
  task automatic t_seqerr();
    int n0;
    for (int p = 1; p < 3; p++)
    begin
      wbw(AIC_OFS_IRQ_STATUS, 7);
      wbw(AIC_OFS_IRQ_MASK, (p == 2) ? 4 : 0);
      wbw(AIC_OFS_INPUT_CFG, p);
      wbw(AIC_OFS_SEQ_CHEN, 3);
      cyc_n(3);
      rc(AIC_OFS_SEQ_STATUS, 1);
      chk("irq", p == 2, irq);
      n0 = nStart;
      wbw(AIC_OFS_CONV_START, 1);
      cyc_n(30);
      chk("refused", n0, nStart);
      wbw(AIC_OFS_SEQ_CHEN, 1);
      wbw(AIC_OFS_IRQ_STATUS, 4);
      cyc_n(3);
      chk("irq", 0, irq);
      wait_idle();
      wbw(AIC_OFS_CONV_START, 1);
      wait_idle();
      rc(AIC_OFS_RESULT, 32'h800);
    end
    wbw(AIC_OFS_INPUT_CFG, 0);
    wbw(AIC_OFS_IRQ_MASK, 0);
  endtask
  task automatic meas(input logic [7:0] n, input logic o, output int c);
    int n0;
    wbw(AIC_OFS_NCLK, n);
    wbw(AIC_OFS_OSC, o);
    n0 = nStart;
    wbw(AIC_OFS_CONV_START, 1);
    c = 0;
    while (nStart == n0 && c < 5000)
    begin
      @(posedge clk);
      c++;
    end
    wait_idle();
  endtask
  // cycle length and oscillator choice set the time to the start pulse
  task automatic t_rate();
    int a, b, c, d;
    meas(2, 0, a);
    meas(9, 0, b);
    chk("hso", 7, b - a);
    meas(2, 1, c);
    meas(9, 1, d);
    chk("lpo", 1, (d - c) >= 25 && (d - c) <= 31);
    wbw(AIC_OFS_OSC, 0);
  endtask
  // strap kept after power-up, reprogram, relatch on reset
  task automatic t_addr();
    strap <= 3'h1;
    cyc_n(10);
    chk("addr", 7'h1e, slaveAddr);
    wbw(AIC_OFS_SLAVE_ADDR, 7'h1b);
    cyc_n(3);
    chk("addr", 7'h1b, slaveAddr);
    wbw(AIC_OFS_INPUT_CFG, 2);
    do_reset();
    chk("addr", 7'h19, slaveAddr);
    rc(AIC_OFS_INPUT_CFG, 0);
  endtask
  // main sequence
  initial
  begin
    nrst = 0;
    cyc = 0;
    stb = 0;
    we = 0;
    adr = 0;
    sel = 4'hf;
    dat = 0;
    strap = 3'h6;
    convCode = 12'h805;
    calCode = 12'h805;
    do_reset();
    t_defaults();
    t_manual();
    t_cal();
    t_modes();
    t_seqerr();
    t_rate();
    t_addr();
    conclude();
  end
endmodule
